// ==== shared/ctr16_pkg.sv ====
// Constants, register map and decode helpers for the 16-bit capture counter.
// Assumes both the counter end and the CPU-side controller import it whole.
// How it works
// - Shared upper byte written once, sequence atomic.
// - Clock-select field picks tick; zero stops.
// - Sixteen-bit counter steps by one or clears.
// - Upper-byte location reaches shared temporary byte.
// - Lower read loads temp; lower write commits.
// - Counter reachable whether or not ticking.
// - CPU counter write beats clear or count.
// - Four-bit mode field split over controls A/B.
// - Overflow flag set per mode, raises interrupt.
// - Qualified trigger edge copies counter to capture.
// - Capture flag set with capture register load.
// - Enabled capture flag requests interrupt; ack clears.
// - Writing one clears capture flag; zero ignored.
// - Capture read low first, upper from temp.
// - Capture writable only in top modes, upper first.
// - First instance may trigger from comparator output.
// - Clear capture flag after switching trigger source.
// - Filter output changes after four equal samples.
// - Filter enable bit; four cycles; system clock.
// - Trigger path idle in capture-as-top modes.
// - Driving the pin forces a capture.
// - New capture overwrites, no overrun flag.
// - Lower-byte write loads whole register at once.
package ctr16_pkg;
  localparam int ADDR_W = 4;
  // Byte locations on the device side.
  localparam logic [3:0] A_CTRL_A = 4'h0;
  localparam logic [3:0] A_CTRL_B = 4'h1;
  localparam logic [3:0] A_CNT_LO = 4'h2;
  localparam logic [3:0] A_CNT_HI = 4'h3;
  localparam logic [3:0] A_CAP_LO = 4'h4;
  localparam logic [3:0] A_CAP_HI = 4'h5;
  localparam logic [3:0] A_FLAGS = 4'h6;
  localparam logic [3:0] A_MASK = 4'h7;
  localparam logic [3:0] A_CMP = 4'h8;
  // Field positions.
  localparam int B_OVF = 0;
  localparam int B_CAP = 5;
  localparam int B_CS_LSB = 0;
  localparam int B_WGMH_LSB = 3;
  localparam int B_EDGE = 6;
  localparam int B_NC = 7;
  localparam int B_WGML_LSB = 0;
  localparam int B_CMP_SEL = 2;
  // Reset values.
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [9:0] PRE_RST = 10'h000;
  // Counting modes and clock selects.
  localparam logic [3:0] WGM_DUAL_ICR_A = 4'h8;
  localparam logic [3:0] WGM_DUAL_ICR_B = 4'hA;
  localparam logic [3:0] WGM_CLR_ICR = 4'hC;
  localparam logic [3:0] WGM_FAST_ICR = 4'hE;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int FILT_SAMPLES = 4;
  // Controller-side user registers.
  localparam logic [2:0] U_TARGET = 3'h0;
  localparam logic [2:0] U_DLO = 3'h1;
  localparam logic [2:0] U_DHI = 3'h2;
  localparam logic [2:0] U_CMD = 3'h3;
  localparam logic [2:0] U_STAT = 3'h4;
  localparam int C_WR16 = 0;
  localparam int C_RD16 = 1;
  localparam int C_REUSE = 2;
  localparam int C_WR8 = 3;
  localparam int C_RD8 = 4;
  localparam int S_BUSY = 0;
  localparam int S_CAPIRQ = 1;
  localparam int S_OVFIRQ = 2;

  // True for modes in which the capture register sets the counter top.
  function automatic logic icr_top(input logic [3:0] wgm);
    icr_top = (wgm == WGM_DUAL_ICR_A) || (wgm == WGM_DUAL_ICR_B) ||
              (wgm == WGM_CLR_ICR) || (wgm == WGM_FAST_ICR);
  endfunction : icr_top
endpackage : ctr16_pkg

// ==== shared/ctr16_if.sv ====
// Byte bus between the CPU-side controller and the capture counter.
// Assumes one shared clock; the testbench instantiates it and joins the ends.
`timescale 1ns/1ps
interface ctr16_if;
  logic [ctr16_pkg::ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic we;
  logic re;
  logic [7:0] rdata;
  logic ovf_irq;
  logic cap_irq;
  logic ovf_ack;
  logic cap_ack;
  modport dev (input addr, wdata, we, re, ovf_ack, cap_ack, output rdata, ovf_irq, cap_irq);
  modport cpu (output addr, wdata, we, re, ovf_ack, cap_ack, input rdata, ovf_irq, cap_irq);
endinterface : ctr16_if

// ==== rtl/ctr16_noise_filt.sv ====
// Four-sample majority-free noise canceller for the capture trigger.
// Assumes a synchronised input and the system clock; bypassed when disabled.
`timescale 1ns/1ps
module ctr16_noise_filt (
  // Clock and control.
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic enable_i,
  // Data.
  input wire logic din_i,
  output logic dout_o
);
  import ctr16_pkg::*;
  logic [FILT_SAMPLES-1:0] hist_q;

  // Sample history runs on the system clock, never the prescaled tick.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hist_q <= '0;
    end else if (ce_i) begin
      hist_q <= {hist_q[FILT_SAMPLES-2:0], din_i};
    end
  end

  // Output moves only when the whole history agrees, costing four extra cycles.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      dout_o <= 1'b0;
    end else if (ce_i) begin
      if (!enable_i) begin
        dout_o <= din_i;
      end else if ((&hist_q) || !(|hist_q)) begin
        dout_o <= hist_q[FILT_SAMPLES-1];
      end
    end
  end
endmodule : ctr16_noise_filt

// ==== rtl/ctr16_dev.sv ====
// The 16-bit counter with input capture, seen through its byte bus.
// Assumes asynchronous inputs are re-synchronised here and one system clock.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module ctr16_dev #(
  parameter bit HAS_CMP = 1'b1
) (
  // Clock, reset, enable.
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // CPU side.
  ctr16_if.dev bus,
  // Trigger and clock inputs.
  input wire logic capture_pin_i,
  input wire logic comparator_output_i,
  input wire logic ext_clk_i,
  // Observation.
  output logic [15:0] count_value_o
);
  import ctr16_pkg::*;

  logic [7:0] ctrl_a_q, ctrl_b_q, mask_q, cmp_q, temp_q, rdata_q;
  logic [15:0] cnt_q, icr_q;
  logic [9:0] pre_q;
  logic dir_down_q, ovf_q, cap_q, ovf_irq_q, cap_irq_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q, trg_s1_q, trg_s2_q, filt, filt_prev_q;
  logic [3:0] wgm;
  logic [2:0] cs;
  logic tick, cnt_wr, icr_wr, ovf_ev, cap_ev, trg_raw, top_mode;

  assign wgm = {ctrl_b_q[B_WGMH_LSB+1:B_WGMH_LSB], ctrl_a_q[B_WGML_LSB+1:B_WGML_LSB]};
  assign cs = ctrl_b_q[B_CS_LSB+2:B_CS_LSB];
  assign top_mode = icr_top(wgm);
  assign cnt_wr = bus.we && (bus.addr == A_CNT_LO);
  assign icr_wr = bus.we && (bus.addr == A_CAP_LO) && top_mode;

  // Control registers; writes to unmapped locations are dropped.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_a_q <= REG8_RST;
      ctrl_b_q <= REG8_RST;
      mask_q <= REG8_RST;
      cmp_q <= REG8_RST;
    end else if (ce_i && bus.we) begin
      case (bus.addr)
        A_CTRL_A: ctrl_a_q <= bus.wdata;
        A_CTRL_B: ctrl_b_q <= bus.wdata;
        A_MASK: mask_q <= bus.wdata;
        A_CMP: cmp_q <= bus.wdata;
        default: ;
      endcase
    end
  end

  // One temporary byte serves every 16-bit register of this counter.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      temp_q <= REG8_RST;
    end else if (ce_i) begin
      if (bus.we && (bus.addr == A_CNT_HI || bus.addr == A_CAP_HI)) begin
        temp_q <= bus.wdata;
      end else if (bus.re && bus.addr == A_CNT_LO) begin
        temp_q <= cnt_q[15:8];
      end else if (bus.re && bus.addr == A_CAP_LO) begin
        temp_q <= icr_q[15:8];
      end
    end
  end

  // Free-running prescaler and external clock synchroniser.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pre_q <= PRE_RST;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else if (ce_i) begin
      pre_q <= pre_q + 10'h001;
      ext_s1_q <= ext_clk_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // Timer tick selection; the stop code yields no tick at all.
  always_comb begin
    case (cs)
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = &pre_q[2:0];
      CS_DIV64: tick = &pre_q[5:0];
      CS_DIV256: tick = &pre_q[7:0];
      CS_DIV1024: tick = &pre_q;
      CS_EXT_FALL: tick = ext_s3_q && !ext_s2_q;
      CS_EXT_RISE: tick = ext_s2_q && !ext_s3_q;
      default: tick = 1'b0;
    endcase
  end

  // Overflow point depends on the counting mode.
  always_comb begin
    ovf_ev = 1'b0;
    if (tick && !cnt_wr) begin
      case (wgm)
        WGM_DUAL_ICR_A, WGM_DUAL_ICR_B: ovf_ev = dir_down_q && (cnt_q == CNT_BOTTOM);
        WGM_FAST_ICR: ovf_ev = (cnt_q >= icr_q);
        default: ovf_ev = (cnt_q == CNT_MAX);
      endcase
    end
  end

  // Counter: a CPU write always wins over count or clear in the same cycle.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cnt_q <= CNT_RST;
      dir_down_q <= 1'b0;
    end else if (ce_i) begin
      if (cnt_wr) begin
        cnt_q <= {temp_q, bus.wdata};
      end else if (tick) begin
        case (wgm)
          WGM_DUAL_ICR_A, WGM_DUAL_ICR_B: begin
            if (!dir_down_q && cnt_q >= icr_q) begin
              dir_down_q <= 1'b1;
              cnt_q <= cnt_q - 16'h0001;
            end else if (dir_down_q && cnt_q == CNT_BOTTOM) begin
              dir_down_q <= 1'b0;
              cnt_q <= cnt_q + 16'h0001;
            end else if (dir_down_q) begin
              cnt_q <= cnt_q - 16'h0001;
            end else begin
              cnt_q <= cnt_q + 16'h0001;
            end
          end
          WGM_CLR_ICR, WGM_FAST_ICR: begin
            cnt_q <= (cnt_q >= icr_q) ? CNT_BOTTOM : cnt_q + 16'h0001;
          end
          default: begin
            dir_down_q <= 1'b0;
            cnt_q <= cnt_q + 16'h0001;
          end
        endcase
      end
    end
  end

  // Trigger source mux; a pin driven by its own port counts like any event.
  assign trg_raw = (HAS_CMP && cmp_q[B_CMP_SEL]) ? comparator_output_i : capture_pin_i;

  // Two-flop synchroniser ahead of the filter.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      trg_s1_q <= 1'b0;
      trg_s2_q <= 1'b0;
    end else if (ce_i) begin
      trg_s1_q <= trg_raw;
      trg_s2_q <= trg_s1_q;
    end
  end

  ctr16_noise_filt u_filt (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .enable_i(ctrl_b_q[B_NC]),
    .din_i(trg_s2_q),
    .dout_o(filt)
  );

  // Edge detector; the polarity bit picks rising when set.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      filt_prev_q <= 1'b0;
    end else if (ce_i) begin
      filt_prev_q <= filt;
    end
  end
  assign cap_ev = !top_mode && (ctrl_b_q[B_EDGE] ? (filt && !filt_prev_q) : (!filt && filt_prev_q));

  // Capture register; a fresh event simply overwrites an unread value.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      icr_q <= CNT_RST;
    end else if (ce_i) begin
      if (cap_ev) begin
        icr_q <= cnt_q;
      end else if (icr_wr) begin
        icr_q <= {temp_q, bus.wdata};
      end
    end
  end

  // Sticky flags: a hardware set in the clearing cycle survives.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ovf_q <= 1'b0;
      cap_q <= 1'b0;
    end else if (ce_i) begin
      if (ovf_ev) begin
        ovf_q <= 1'b1;
      end else if (bus.ovf_ack || (bus.we && bus.addr == A_FLAGS && bus.wdata[B_OVF])) begin
        ovf_q <= 1'b0;
      end
      if (cap_ev) begin
        cap_q <= 1'b1;
      end else if (bus.cap_ack || (bus.we && bus.addr == A_FLAGS && bus.wdata[B_CAP])) begin
        cap_q <= 1'b0;
      end
    end
  end

  // Interrupt requests are registered, so they trail the flag by a cycle.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ovf_irq_q <= 1'b0;
      cap_irq_q <= 1'b0;
    end else if (ce_i) begin
      ovf_irq_q <= ovf_q && mask_q[B_OVF];
      cap_irq_q <= cap_q && mask_q[B_CAP];
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_q <= REG8_RST;
    end else if (ce_i) begin
      rdata_q <= REG8_RST;
      if (bus.re) begin
        case (bus.addr)
          A_CTRL_A: rdata_q <= ctrl_a_q;
          A_CTRL_B: rdata_q <= ctrl_b_q;
          A_CNT_LO: rdata_q <= cnt_q[7:0];
          A_CNT_HI, A_CAP_HI: rdata_q <= temp_q;
          A_CAP_LO: rdata_q <= icr_q[7:0];
          A_FLAGS: rdata_q <= {2'b00, cap_q, 4'h0, ovf_q};
          A_MASK: rdata_q <= mask_q;
          A_CMP: rdata_q <= cmp_q;
          default: rdata_q <= REG8_RST;
        endcase
      end
    end
  end

  assign bus.rdata = rdata_q;
  assign bus.ovf_irq = ovf_irq_q;
  assign bus.cap_irq = cap_irq_q;
  assign count_value_o = cnt_q;
endmodule : ctr16_dev

// ==== rtl/ctr16_host.sv ====
// CPU-side controller that turns user commands into byte-bus sequences.
// Assumes it is the only master on the counter's byte bus.
`timescale 1ns/1ps
module ctr16_host (
  // Clock, reset, enable.
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // User command port.
  input wire logic [2:0] uaddr_i,
  input wire logic [7:0] uwdata_i,
  input wire logic uwe_i,
  input wire logic ure_i,
  output logic [7:0] urdata_o,
  // Counter side.
  ctr16_if.cpu bus
);
  import ctr16_pkg::*;
  typedef enum logic [2:0] {H_IDLE, H_WR_HI, H_WR_LO, H_RD_LO, H_RD_HI, H_RD_END, H_RD_FIN, H_CLR} ctr16_hst_e;
  ctr16_hst_e st_q;
  logic [3:0] target_q, addr_q;
  logic [7:0] dlo_q, dhi_q, wdata_q, last_hi_q, urdata_q;
  logic we_q, re_q, oack_q, cack_q, single_q, last_ok_q, busy;
  logic cmd;

  assign busy = (st_q != H_IDLE);
  assign cmd = uwe_i && uaddr_i == U_CMD && !busy;

  // Sequencer; serialising every access keeps the shared temp byte atomic.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_q <= H_IDLE;
      addr_q <= 4'h0;
      wdata_q <= REG8_RST;
      we_q <= 1'b0;
      re_q <= 1'b0;
      single_q <= 1'b0;
      last_hi_q <= REG8_RST;
      last_ok_q <= 1'b0;
    end else if (ce_i) begin
      we_q <= 1'b0;
      re_q <= 1'b0;
      case (st_q)
        H_IDLE: begin
          if (cmd && uwdata_i[C_WR16]) begin
            // Skip the upper byte when it already sits in the temp byte.
            st_q <= (uwdata_i[C_REUSE] && last_ok_q && last_hi_q == dhi_q) ? H_WR_LO : H_WR_HI;
          end else if (cmd && uwdata_i[C_WR8]) begin
            st_q <= H_WR_LO;
          end else if (cmd && (uwdata_i[C_RD16] || uwdata_i[C_RD8])) begin
            single_q <= uwdata_i[C_RD8] && !uwdata_i[C_RD16];
            st_q <= H_RD_LO;
          end
        end
        H_WR_HI: begin
          we_q <= 1'b1;
          addr_q <= target_q + 4'h1;
          wdata_q <= dhi_q;
          last_hi_q <= dhi_q;
          last_ok_q <= 1'b1;
          st_q <= H_WR_LO;
        end
        H_WR_LO: begin
          we_q <= 1'b1;
          addr_q <= target_q;
          wdata_q <= dlo_q;
          st_q <= (target_q == A_CMP) ? H_CLR : H_IDLE;
        end
        H_CLR: begin
          we_q <= 1'b1;
          addr_q <= A_FLAGS;
          wdata_q <= 8'h20;
          st_q <= H_IDLE;
        end
        H_RD_LO: begin
          re_q <= 1'b1;
          addr_q <= target_q;
          st_q <= H_RD_HI;
          last_ok_q <= 1'b0;
        end
        H_RD_HI: begin
          re_q <= !single_q;
          addr_q <= target_q + 4'h1;
          st_q <= H_RD_END;
        end
        // Read data trails its strobe by a cycle, so each byte lands one state later.
        H_RD_END: st_q <= single_q ? H_IDLE : H_RD_FIN;
        H_RD_FIN: st_q <= H_IDLE;
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // User registers; read results land in the data registers.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      target_q <= 4'h0;
      dlo_q <= REG8_RST;
      dhi_q <= REG8_RST;
    end else if (ce_i) begin
      if (st_q == H_RD_END) begin
        dlo_q <= bus.rdata;
      end else if (st_q == H_RD_FIN) begin
        dhi_q <= bus.rdata;
      end else if (uwe_i && !busy) begin
        case (uaddr_i)
          U_TARGET: target_q <= uwdata_i[3:0];
          U_DLO: dlo_q <= uwdata_i;
          U_DHI: dhi_q <= uwdata_i;
          default: ;
        endcase
      end
    end
  end

  // Interrupt acknowledges and user read-back.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      oack_q <= 1'b0;
      cack_q <= 1'b0;
      urdata_q <= REG8_RST;
    end else if (ce_i) begin
      oack_q <= uwe_i && uaddr_i == U_STAT && uwdata_i[S_OVFIRQ];
      cack_q <= uwe_i && uaddr_i == U_STAT && uwdata_i[S_CAPIRQ];
      urdata_q <= REG8_RST;
      if (ure_i) begin
        case (uaddr_i)
          U_TARGET: urdata_q <= {4'h0, target_q};
          U_DLO: urdata_q <= dlo_q;
          U_DHI: urdata_q <= dhi_q;
          U_STAT: urdata_q <= {5'h00, bus.ovf_irq, bus.cap_irq, busy};
          default: urdata_q <= REG8_RST;
        endcase
      end
    end
  end

  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.we = we_q;
  assign bus.re = re_q;
  assign bus.ovf_ack = oack_q;
  assign bus.cap_ack = cack_q;
  assign urdata_o = urdata_q;
endmodule : ctr16_host

// ==== tb/ctr16_asserts.sv ====
// Concurrent checks on the byte bus joining the controller and the counter.
// Assumes the bench places it beside the interface and the counter output.
`timescale 1ns/1ps
module ctr16_asserts (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic reset_i,
  // Byte bus and counter observation.
  input wire logic [ctr16_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic we,
  input wire logic re,
  input wire logic [7:0] rdata,
  input wire logic ovf_irq,
  input wire logic cap_irq,
  input wire logic ovf_ack,
  input wire logic cap_ack,
  input wire logic [15:0] count_value_o
);
  import ctr16_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Overlapping strobes would let one access corrupt the shared upper byte.
  property p_one_strobe; !(we && re); endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("strobes overlap");
  // Read data stands only in the cycle after a read.
  property p_rdata_idle; !$past(re) |-> rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
  // Upper then lower write moves the whole value at once, even while counting.
  property p_cnt_commit;
    we && addr == A_CNT_HI ##1 we && addr == A_CNT_LO |=> count_value_o == {$past(wdata, 2), $past(wdata)};
  endproperty
  a_cnt_commit: assert property (p_cnt_commit) else $error("counter not loaded whole");
  property p_cnt_low; we && addr == A_CNT_LO |=> count_value_o[7:0] == $past(wdata); endproperty
  a_cnt_low: assert property (p_cnt_low) else $error("counter low byte not written");
  // Without a CPU write the counter only holds, steps by one or clears.
  property p_cnt_step;
    !$past(we) |-> count_value_o == $past(count_value_o) || count_value_o == $past(count_value_o) + 16'h0001 ||
      count_value_o == $past(count_value_o) - 16'h0001 || count_value_o == 16'h0000;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter jumped");
  property p_cap_rd_order; re && addr == A_CAP_HI |-> $past(re) && $past(addr) == A_CAP_LO; endproperty
  a_cap_rd_order: assert property (p_cap_rd_order) else $error("capture upper read alone");
  property p_cap_wr_order; we && addr == A_CAP_LO |-> $past(we) && $past(addr) == A_CAP_HI; endproperty
  a_cap_wr_order: assert property (p_cap_wr_order) else $error("capture lower written first");
  // Request lines lag the flag by one cycle, hence the two-cycle window.
  property p_flag_w1c; we && addr == A_FLAGS && wdata[B_CAP] |-> ##[1:2] !cap_irq; endproperty
  a_flag_w1c: assert property (p_flag_w1c) else $error("capture flag not cleared");
  property p_cap_ack; cap_ack |-> ##[1:2] !cap_irq; endproperty
  a_cap_ack: assert property (p_cap_ack) else $error("capture ack ignored");
  property p_ovf_ack; ovf_ack |-> ##[1:2] !ovf_irq; endproperty
  a_ovf_ack: assert property (p_ovf_ack) else $error("overflow ack ignored");
endmodule : ctr16_asserts

// ==== tb/ctr16_bench.sv ====
// Self-checking bench: user commands into the controller, counter on the far side.
// Assumes the package, interface and both design ends compile before it.
`timescale 1ns/1ps
module ctr16_bench;
  import ctr16_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic [2:0] uaddr_i = 3'h0;
  logic [7:0] uwdata_i = 8'h00;
  logic uwe_i = 1'b0;
  logic ure_i = 1'b0;
  logic [7:0] urdata_o;
  logic capture_pin_i = 1'b0;
  logic comparator_output_i = 1'b0;
  logic ext_clk_i = 1'b0;
  logic [15:0] count_value_o;
  logic [15:0] v;
  logic [15:0] w;
  logic [7:0] s;
  logic [3:0] top [4] = '{WGM_DUAL_ICR_A, WGM_DUAL_ICR_B, WGM_CLR_ICR, WGM_FAST_ICR};
  int err_count = 0;
  int comparisons = 0;
  int n0;
  int n1;
  ctr16_if bus_if ();
  ctr16_host i_ctr16_host (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .uaddr_i(uaddr_i),
    .uwdata_i(uwdata_i), .uwe_i(uwe_i), .ure_i(ure_i), .urdata_o(urdata_o), .bus(bus_if));
  ctr16_dev #(.HAS_CMP(1'b1)) i_ctr16_dev (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .bus(bus_if),
    .capture_pin_i(capture_pin_i), .comparator_output_i(comparator_output_i), .ext_clk_i(ext_clk_i),
    .count_value_o(count_value_o));
  ctr16_asserts i_ctr16_asserts (.mclk_i(mclk_i), .reset_i(reset_i), .addr(bus_if.addr), .wdata(bus_if.wdata),
    .we(bus_if.we), .re(bus_if.re), .rdata(bus_if.rdata), .ovf_irq(bus_if.ovf_irq), .cap_irq(bus_if.cap_irq),
    .ovf_ack(bus_if.ovf_ack), .cap_ack(bus_if.cap_ack), .count_value_o(count_value_o));
  // System clock and a free external tick source at half its rate.
  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) ext_clk_i <= ~ext_clk_i;
  task automatic cmp16(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp16
  task automatic cmp1(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask : cmp1
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  // User port accesses; strobes are one cycle and taken at the following edge.
  task automatic uwr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    uaddr_i <= a;
    uwdata_i <= d;
    uwe_i <= 1'b1;
    @(posedge mclk_i);
    uwe_i <= 1'b0;
  endtask : uwr
  task automatic urd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    uaddr_i <= a;
    ure_i <= 1'b1;
    @(posedge mclk_i);
    ure_i <= 1'b0;
    #1;
    d = urdata_o;
  endtask : urd
  // Commands are dropped while busy, so every sequence waits here after its command.
  task automatic idle();
    for (int i = 0; i < 40; i++) begin
      urd(U_STAT, s);
      if (s[S_BUSY] === 1'b0) return;
    end
    cmp1("host idle", 1'b0, s[S_BUSY]);
  endtask : idle
  task automatic wr16(input logic [3:0] t, input logic [15:0] d, input bit reuse);
    uwr(U_TARGET, {4'h0, t});
    uwr(U_DLO, d[7:0]);
    uwr(U_DHI, d[15:8]);
    uwr(U_CMD, reuse ? 8'h05 : 8'h01);
    idle();
  endtask : wr16
  task automatic rd16(input logic [3:0] t, output logic [15:0] d);
    uwr(U_TARGET, {4'h0, t});
    uwr(U_CMD, 8'h02);
    idle();
    urd(U_DLO, d[7:0]);
    urd(U_DHI, d[15:8]);
  endtask : rd16
  task automatic wr8(input logic [3:0] t, input logic [7:0] d);
    uwr(U_TARGET, {4'h0, t});
    uwr(U_DLO, d);
    uwr(U_CMD, 8'h08);
    idle();
  endtask : wr8
  task automatic pin(input logic lvl);
    @(posedge mclk_i);
    capture_pin_i <= lvl;
    repeat (12) @(posedge mclk_i);
  endtask : pin
  // Cycles from a rising pin to the capture request; the flag is cleared after.
  task automatic lat(output int n);
    @(posedge mclk_i);
    capture_pin_i <= 1'b1;
    n = 0;
    while (bus_if.cap_irq !== 1'b1 && n < 40) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    pin(1'b0);
    wr8(A_FLAGS, 8'h20);
  endtask : lat
  initial begin
    repeat (40000) @(posedge mclk_i);
    err_count++;
    results();
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    wr16(A_CNT_LO, 16'h01FF, 1'b0);
    cmp16("count flop", 16'h01FF, count_value_o);
    wr16(A_CNT_LO, 16'h0111, 1'b1);
    rd16(A_CNT_LO, v);
    cmp16("count read", 16'h0111, v);
    $display("test access done");
    for (int cs = 1; cs < 8; cs++) begin
      wr16(A_CNT_LO, 16'h0000, 1'b0);
      wr8(A_CTRL_B, 8'(cs));
      repeat (1100) @(posedge mclk_i);
      wr8(A_CTRL_B, {5'h00, CS_STOP});
      rd16(A_CNT_LO, v);
      cmp1("count moved", 1'b1, v != 16'h0000);
      repeat (20) @(posedge mclk_i);
      rd16(A_CNT_LO, w);
      cmp16("count held", v, w);
    end
    $display("test clock select done");
    wr8(A_MASK, 8'h21);
    wr8(A_CTRL_B, {5'h00, CS_DIV1});
    @(posedge mclk_i);
    #1;
    v = count_value_o;
    @(posedge mclk_i);
    #1;
    cmp16("count step", v + 16'h0001, count_value_o);
    wr16(A_CNT_LO, 16'hFFF0, 1'b0);
    repeat (40) @(posedge mclk_i);
    wr8(A_CTRL_B, 8'h00);
    urd(U_STAT, s);
    cmp1("overflow irq", 1'b1, s[S_OVFIRQ]);
    uwr(U_STAT, 8'h04);
    repeat (3) @(posedge mclk_i);
    urd(U_STAT, s);
    cmp1("overflow ack", 1'b0, s[S_OVFIRQ]);
    $display("test overflow done");
    wr16(A_CNT_LO, 16'h0100, 1'b0);
    wr8(A_CTRL_B, 8'h40);
    pin(1'b1);
    rd16(A_CAP_LO, v);
    cmp16("capture rise", 16'h0100, v);
    urd(U_STAT, s);
    cmp1("capture irq", 1'b1, s[S_CAPIRQ]);
    wr16(A_CNT_LO, 16'h0200, 1'b0);
    pin(1'b0);
    rd16(A_CAP_LO, v);
    cmp16("capture polarity", 16'h0100, v);
    wr8(A_CTRL_B, 8'h00);
    pin(1'b1);
    pin(1'b0);
    rd16(A_CAP_LO, v);
    cmp16("capture overwrite", 16'h0200, v);
    wr8(A_FLAGS, 8'h00);
    urd(U_STAT, s);
    cmp1("flag kept", 1'b1, s[S_CAPIRQ]);
    wr8(A_FLAGS, 8'h20);
    urd(U_STAT, s);
    cmp1("flag cleared", 1'b0, s[S_CAPIRQ]);
    $display("test capture done");
    wr8(A_CTRL_B, 8'h40);
    lat(n0);
    wr8(A_CTRL_B, 8'hC0);
    lat(n1);
    cmp16("filter delay", 16'h0004, 16'(n1 - n0));
    @(posedge mclk_i);
    capture_pin_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    capture_pin_i <= 1'b0;
    repeat (15) @(posedge mclk_i);
    urd(U_STAT, s);
    cmp1("spike rejected", 1'b0, s[S_CAPIRQ]);
    $display("test filter done");
    wr8(A_CTRL_B, 8'h40);
    wr16(A_CAP_LO, 16'h5555, 1'b0);
    rd16(A_CAP_LO, v);
    cmp16("capture write refused", 16'h0200, v);
    foreach (top[i]) begin
      wr8(A_CTRL_A, {6'h00, top[i][1:0]});
      wr8(A_CTRL_B, {3'h2, top[i][3:2], 3'h0});
      wr16(A_CAP_LO, {8'h0A, 4'h0, top[i]}, 1'b0);
      pin(1'b1);
      pin(1'b0);
      rd16(A_CAP_LO, v);
      cmp16("capture as top", {8'h0A, 4'h0, top[i]}, v);
    end
    urd(U_STAT, s);
    cmp1("trigger idle in top modes", 1'b0, s[S_CAPIRQ]);
    $display("test top modes done");
    wr8(A_CTRL_A, 8'h00);
    wr8(A_CTRL_B, 8'h40);
    // A pending capture must be gone once the source switch has been made.
    pin(1'b1);
    wr8(A_CMP, 8'h04);
    urd(U_STAT, s);
    cmp1("flag cleared on source switch", 1'b0, s[S_CAPIRQ]);
    wr16(A_CNT_LO, 16'h0321, 1'b0);
    pin(1'b0);
    pin(1'b1);
    urd(U_STAT, s);
    cmp1("pin ignored", 1'b0, s[S_CAPIRQ]);
    @(posedge mclk_i);
    comparator_output_i <= 1'b1;
    repeat (12) @(posedge mclk_i);
    rd16(A_CAP_LO, v);
    cmp16("comparator capture", 16'h0321, v);
    uwr(U_STAT, 8'h02);
    repeat (3) @(posedge mclk_i);
    urd(U_STAT, s);
    cmp1("capture ack", 1'b0, s[S_CAPIRQ]);
    $display("test comparator done");
    results();
  end
endmodule : ctr16_bench
